// >>> common/sfx_pkg.sv
package sfx_pkg;

  // Data path
  localparam int DATA_W    = 9;
  localparam int DEPTH_DEF = 256;
  localparam int NUM_BUF   = 2;

  // Offsets are 13 bits and counts 14 bits, wide enough for 8K words
  localparam int OFF_W = 13;
  localparam int CMP_W = 14;
  localparam logic [OFF_W-1:0] OFF_RST = 13'h0007;

  // Bus
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;
  localparam int BUS_BW = 4;

  // Register byte addresses
  localparam logic [BUS_AW-1:0] ADDR_AE_OFF_A = 5'h00;
  localparam logic [BUS_AW-1:0] ADDR_AF_OFF_A = 5'h04;
  localparam logic [BUS_AW-1:0] ADDR_AE_OFF_B = 5'h08;
  localparam logic [BUS_AW-1:0] ADDR_AF_OFF_B = 5'h0c;
  localparam logic [BUS_AW-1:0] ADDR_STATUS   = 5'h10;
  localparam logic [BUS_AW-1:0] ADDR_LEVEL_A  = 5'h14;
  localparam logic [BUS_AW-1:0] ADDR_LEVEL_B  = 5'h18;

  // Status field positions, buffer B sits ST_STRIDE above buffer A
  localparam int ST_EMPTY_N  = 0;
  localparam int ST_FULL_N   = 1;
  localparam int ST_NEMPTY_N = 2;
  localparam int ST_NFULL_N  = 3;
  localparam int ST_DUAL     = 4;
  localparam int ST_STRIDE   = 8;

  function automatic logic [CMP_W-1:0] sfx_bin2gray(input logic [CMP_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CMP_W-1:0] sfx_gray2bin(input logic [CMP_W-1:0] g);
    logic [CMP_W-1:0] b;
    b = g;
    for (int k = 1; k < CMP_W; k++) begin
      b = b ^ (g >> k);
    end
    return b;
  endfunction

endpackage

// >>> dv/sfx_fifo_monitor.sv
`timescale 1ns/10ps
module sfx_fifo_monitor (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  // Bus handshake
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic                       avs_waitrequest,
  // Buffer A
  input wire logic                       buf_clear_a,
  input wire logic                       store_clk_a,
  input wire logic                       fetch_clk_a,
  input wire logic                       fetch_en_first_a,
  input wire logic                       fetch_en_second_a,
  input wire logic                       out_drive_a,
  input wire logic [sfx_pkg::DATA_W-1:0] data_out_a,
  input wire logic                       data_drive_a,
  input wire logic                       buf_empty_n_a,
  input wire logic                       buf_full_n_a,
  input wire logic                       near_empty_n_a,
  input wire logic                       near_full_n_a
);
  import sfx_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  empty_edge_a:
  assert property (!$stable({buf_empty_n_a, near_empty_n_a}) && !$past(buf_clear_a)
    |-> $past(fetch_clk_a) && !$past(fetch_clk_a, 2)) else $error("empty flags off read edge");
  full_edge_a:
  assert property (!$stable({buf_full_n_a, near_full_n_a}) && !$past(buf_clear_a)
    |-> $past(store_clk_a) && !$past(store_clk_a, 2)) else $error("full flags off write edge");
  empty_hold_a:
  assert property (!$stable(buf_empty_n_a) && !buf_clear_a |=> $stable(buf_empty_n_a))
    else $error("empty flag held under one cycle");
  full_hold_a:
  assert property (!$stable(buf_full_n_a) && !buf_clear_a |=> $stable(buf_full_n_a))
    else $error("full flag held under one cycle");
  fetch_gate_a:
  assert property (!$stable(data_out_a) |-> $past(fetch_clk_a) && !$past(fetch_clk_a, 2)
    && !$past(fetch_en_first_a) && !$past(fetch_en_second_a) && $past(buf_empty_n_a))
    else $error("output word changed without a fetch");
  drive_follow_a:
  assert property (##1 data_drive_a == $past(out_drive_a)) else $error("drive not following");
  empty_near_a:
  assert property (!buf_empty_n_a |-> !near_empty_n_a) else $error("empty but not near empty");
  full_near_a:
  assert property (!buf_full_n_a |-> !near_full_n_a) else $error("full but not near full");
  bus_answer_a:
  assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest) else $error("bus answer not in one cycle");
  full_seen_c: cover property (!buf_full_n_a);
  fetch_seen_c: cover property (!$stable(data_out_a));
  drive_seen_c: cover property ($rose(data_drive_a));
endmodule // sfx_fifo_monitor

bind sfx_dual_fifo sfx_fifo_monitor mon (.ref_clk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .buf_clear_a, .store_clk_a, .fetch_clk_a, .fetch_en_first_a,
  .fetch_en_second_a, .out_drive_a, .data_out_a, .data_drive_a, .buf_empty_n_a,
  .buf_full_n_a, .near_empty_n_a, .near_full_n_a);

// >>> dv/sfx_stream_agent.sv
`timescale 1ns/10ps
module sfx_stream_agent (
  // Clock and buffer answers
  input  wire logic                       ref_clk,
  input  wire logic                       full_n,
  input  wire logic                       empty_n,
  input  wire logic [sfx_pkg::DATA_W-1:0] dout,
  // Producer pins
  input  wire logic                       st_en2,
  output logic                            st_clk,
  output logic                            st_en_n,
  output logic      [sfx_pkg::DATA_W-1:0] din,
  // Consumer pins
  output logic                            ft_clk,
  output logic      [1:0]                 ft_en_n
);
  import sfx_pkg::*;
  int                wr_left = 0;
  int                rd_left = 0;
  int                wr_half = 1;
  int                rd_half = 1;
  int                wc      = 0;
  int                rc      = 0;
  logic              hold2   = 1'b0;
  // Buffer strapped to load mode: the primary enable alone requests a store
  logic              loaded  = 1'b0;
  logic              st_q    = 1'b0;
  logic              ft_q    = 1'b0;
  logic              got     = 1'b0;
  logic [DATA_W-1:0] q[$];
  initial begin
    st_clk  = 1'b0;
    st_en_n = 1'b1;
    din     = '0;
    ft_clk  = 1'b0;
    ft_en_n = 2'b11;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Both clocks run free; enables and data move only as their clock rises
  always @(posedge ref_clk) begin
    if (st_clk && !st_q && !st_en_n && (st_en2 || loaded) && full_n)
      q.push_back(din);
    got <= ft_clk && !ft_q && ft_en_n == 2'b00 && empty_n;
    st_q = st_clk;
    ft_q = ft_clk;
    wc++;
    if (wc >= wr_half) begin
      wc = 0;
      st_clk <= !st_clk;
      if (!st_clk) begin
        din     <= DATA_W'($urandom);
        st_en_n <= (wr_left == 0);
        if (wr_left > 0) wr_left--;
      end
    end
    rc++;
    if (rc >= rd_half) begin
      rc = 0;
      ft_clk <= !ft_clk;
      if (!ft_clk) begin
        ft_en_n <= {(rd_left == 0) | hold2, rd_left == 0};
        if (rd_left > 0) rd_left--;
      end
    end
  end
  // A fetched word shows one cycle after its read edge
  always @(posedge ref_clk) begin
    if (got) tb.check(dout, q.pop_front());
  end
endmodule // sfx_stream_agent

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
  import sfx_pkg::*;
  localparam int DEPTH = 256;
  logic                        ref_clk = 1'b0;
  logic                        resetn = 1'b0;
  logic       [BUS_AW-1:0]     avs_address = '0;
  logic                        avs_read = 1'b0;
  logic                        avs_write = 1'b0;
  logic       [BUS_DW-1:0]     avs_writedata = '0;
  logic       [BUS_DW-1:0]     rd;
  logic       [BUS_DW-1:0]     v;
  wire        [BUS_DW-1:0]     avs_readdata;
  wire                         avs_waitrequest;
  logic       [1:0]            clr = 2'b11;
  logic       [1:0]            sec = 2'b11;
  logic       [1:0]            oe = 2'b00;
  wire        [1:0]            sc, se, fc, en, fn, ne, nf, dd;
  wire        [1:0][1:0]       fe;
  wire        [1:0][DATA_W-1:0] di, dq;
  int                          err_total = 0;
  int                          comparisons = 0;
  int                          cyc = 0;
  logic       [BUS_DW-1:0]     regs [8] = '{32'h7, 32'h7, 32'h7, 32'h7, 32'h1a1a, 32'h0,
                                            32'h0, 32'h0};
  initial forever #25 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  sfx_dual_fifo #(.DEPTH(DEPTH)) uut (
    .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .buf_clear_a(clr[0]), .store_clk_a(sc[0]), .store_en_primary_a(se[0]),
    .store_en_secondary_or_load_a(sec[0]), .data_in_a(di[0]), .fetch_clk_a(fc[0]),
    .fetch_en_first_a(fe[0][0]), .fetch_en_second_a(fe[0][1]), .out_drive_a(oe[0]),
    .data_out_a(dq[0]), .data_drive_a(dd[0]), .buf_empty_n_a(en[0]), .buf_full_n_a(fn[0]),
    .near_empty_n_a(ne[0]), .near_full_n_a(nf[0]),
    .buf_clear_b(clr[1]), .store_clk_b(sc[1]), .store_en_primary_b(se[1]),
    .store_en_secondary_or_load_b(sec[1]), .data_in_b(di[1]), .fetch_clk_b(fc[1]),
    .fetch_en_first_b(fe[1][0]), .fetch_en_second_b(fe[1][1]), .out_drive_b(oe[1]),
    .data_out_b(dq[1]), .data_drive_b(dd[1]), .buf_empty_n_b(en[1]), .buf_full_n_b(fn[1]),
    .near_empty_n_b(ne[1]), .near_full_n_b(nf[1]));
  for (genvar i = 0; i < 2; i++) begin : g
    sfx_stream_agent ag (.ref_clk, .full_n(fn[i]), .empty_n(en[i]), .dout(dq[i]),
      .st_en2(sec[i]), .st_clk(sc[i]), .st_en_n(se[i]), .din(di[i]), .ft_clk(fc[i]),
      .ft_en_n(fe[i]));
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [BUS_DW-1:0] seen, input logic [BUS_DW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for the slave however long it takes; only the cycle ceiling ends a hang
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] adr, input logic [BUS_DW-1:0] wd);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Pointer sync and read-edge spacing need a few cycles before flags settle
  // One edge first, so counts just set by the caller have landed in the agents
  task automatic idle();
    @(posedge ref_clk);
    while (g[0].ag.wr_left + g[0].ag.rd_left + g[1].ag.wr_left + g[1].ag.rd_left != 0) begin
      @(posedge ref_clk);
    end
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(58434));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    clr <= 2'b00;
    @(posedge ref_clk);
    check({en, ne, fn, nf}, 8'h0f);
    v = $urandom_range(1, 200);
    bus(1'b1, ADDR_AF_OFF_B, 32'hffff_e000 | v);
    bus(1'b0, ADDR_AF_OFF_B, 32'h0);
    check(rd, v);
    bus(1'b1, ADDR_AF_OFF_B, 32'h7);
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, BUS_AW'(k * 4), 32'h0);
      check(rd, regs[k]);
    end
    $display("Test reset and registers done");
    g[0].ag.wr_left <= 8;
    idle();
    check({en, ne}, 4'h5);
    g[0].ag.rd_left <= 1;
    idle();
    check(ne[0], 1'b0);
    rd = dq[0];
    g[0].ag.hold2 <= 1'b1;
    g[0].ag.rd_left <= 3;
    idle();
    check(dq[0], rd);
    g[0].ag.hold2 <= 1'b0;
    g[0].ag.rd_left <= 9;
    idle();
    check({en[0], 31'(g[0].ag.q.size())}, 32'h0);
    $display("Test near empty and fetch gating done");
    g[0].ag.wr_left <= DEPTH - 8;
    idle();
    check(nf[0], 1'b1);
    g[0].ag.wr_left <= 1;
    idle();
    check({nf[0], fn[0]}, 2'b01);
    g[0].ag.wr_left <= 10;
    idle();
    check(fn[0], 1'b0);
    check(g[0].ag.q.size(), DEPTH);
    check(en[1], 1'b0);
    $display("Test fill to full done");
    g[0].ag.rd_half <= 2;
    g[0].ag.rd_left <= DEPTH + 50;
    g[0].ag.wr_left <= 40;
    idle();
    check({en[0], 31'(g[0].ag.q.size())}, 32'h0);
    $display("Test concurrent streaming done");
    oe <= 2'b01;
    g[1].ag.wr_half <= 3;
    g[1].ag.wr_left <= 20;
    g[1].ag.rd_left <= 80;
    g[0].ag.wr_left <= 5;
    idle();
    check({dd, en}, 4'h5);
    clr <= 2'b01;
    @(posedge ref_clk);
    clr <= 2'b00;
    g[0].ag.q.delete();
    repeat (2) @(posedge ref_clk);
    check({en[0], ne[0], fn[0]}, 3'b001);
    clr <= 2'b10;
    sec <= 2'b01;
    @(posedge ref_clk);
    clr <= 2'b00;
    @(posedge ref_clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0a1a);
    g[1].ag.loaded <= 1'b1;
    g[1].ag.wr_left <= 3;
    g[1].ag.rd_left <= 20;
    idle();
    check({en[1], 31'(g[1].ag.q.size())}, 32'h0);
    $display("Test clear and strap done");
    give_verdict();
  end
endmodule // tb

// >>> hdl/sfx_dual_fifo.sv
`timescale 1ns/10ps
// Behaviour
// - Two separate 9-bit buffers A and B that never interact.
// - Depth is a build parameter, 256 to 8K words, same for both.
// - Store on write-clock rise when primary enable low and, in dual-enable mode, secondary high.
// - One word stored every write-clock cycle while enables stay active.
// - Read port runs on its own read clock with two read enables.
// - Each buffer has its own output enable for its data port.
// - Write and read clocks may be shared or unrelated; both sides run together.
// - Empty, full, near-empty, near-full flags; thresholds programmable per word.
// - Thresholds reset to seven words from empty and from full.
// - Empty-side flags change only on read-clock edges.
// - Full-side flags change only on write-clock edges.
// - A flag that changes holds for at least one cycle of its clock.
// - Stores are ignored while the buffer is full.
// - Fetch only when both read enables low and buffer not empty.
// - Secondary write enable level while clear is held picks dual-enable or load mode.
// - Reset returns a buffer to empty; required before first use.
module sfx_dual_fifo
  import sfx_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  // System clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [BUS_DW-1:0]     avs_writedata,
  input  wire logic [BUS_BW-1:0]     avs_byteenable,
  output logic      [BUS_DW-1:0]     avs_readdata,
  output logic                       avs_waitrequest,
  // Buffer A write side
  input  wire logic                  buf_clear_a,
  input  wire logic                  store_clk_a,
  input  wire logic                  store_en_primary_a,
  input  wire logic                  store_en_secondary_or_load_a,
  input  wire logic [DATA_W-1:0]     data_in_a,
  // Buffer A read side
  input  wire logic                  fetch_clk_a,
  input  wire logic                  fetch_en_first_a,
  input  wire logic                  fetch_en_second_a,
  input  wire logic                  out_drive_a,
  output logic      [DATA_W-1:0]     data_out_a,
  output logic                       data_drive_a,
  // Buffer A flags
  output logic                       buf_empty_n_a,
  output logic                       buf_full_n_a,
  output logic                       near_empty_n_a,
  output logic                       near_full_n_a,
  // Buffer B write side
  input  wire logic                  buf_clear_b,
  input  wire logic                  store_clk_b,
  input  wire logic                  store_en_primary_b,
  input  wire logic                  store_en_secondary_or_load_b,
  input  wire logic [DATA_W-1:0]     data_in_b,
  // Buffer B read side
  input  wire logic                  fetch_clk_b,
  input  wire logic                  fetch_en_first_b,
  input  wire logic                  fetch_en_second_b,
  input  wire logic                  out_drive_b,
  output logic      [DATA_W-1:0]     data_out_b,
  output logic                       data_drive_b,
  // Buffer B flags
  output logic                       buf_empty_n_b,
  output logic                       buf_full_n_b,
  output logic                       near_empty_n_b,
  output logic                       near_full_n_b
);
  import sfx_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0]    DEPTH_P = PW'(DEPTH);
  localparam logic [CMP_W-1:0] DEPTH_C = CMP_W'(DEPTH);

  typedef struct packed {
    logic              wclk_q;
    logic              rclk_q;
    logic              dual;
    logic              oe;
    logic [PW-1:0]     wbin;
    logic [PW-1:0]     wgray;
    logic [PW-1:0]     rbin;
    logic [PW-1:0]     rgray;
    logic              empty_n;
    logic              full_n;
    logic              nempty_n;
    logic              nfull_n;
    logic [DATA_W-1:0] dout;
    logic [CMP_W-1:0]  rlevel;
    logic [OFF_W-1:0]  ae_off;
    logic [OFF_W-1:0]  af_off;
  } sfx_buf_type;

  typedef struct packed {
    logic              waitreq;
    logic [BUS_DW-1:0] rdata;
    sfx_buf_type [NUM_BUF-1:0] fb;
  } sfx_state_type;

  sfx_state_type st_reg;
  sfx_state_type st_next;

  // Storage, one array per buffer
  logic [DATA_W-1:0] mem [NUM_BUF][DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // Pins gathered per buffer
  logic [NUM_BUF-1:0]             clr;
  logic [NUM_BUF-1:0]             wclk_pin;
  logic [NUM_BUF-1:0]             wen1;
  logic [NUM_BUF-1:0]             wen2;
  logic [NUM_BUF-1:0]             rclk_pin;
  logic [NUM_BUF-1:0]             ren1;
  logic [NUM_BUF-1:0]             ren2;
  logic [NUM_BUF-1:0]             oe_pin;
  logic [NUM_BUF-1:0][DATA_W-1:0] din;

  assign clr      = {buf_clear_b, buf_clear_a};
  assign wclk_pin = {store_clk_b, store_clk_a};
  assign wen1     = {store_en_primary_b, store_en_primary_a};
  assign wen2     = {store_en_secondary_or_load_b, store_en_secondary_or_load_a};
  assign rclk_pin = {fetch_clk_b, fetch_clk_a};
  assign ren1     = {fetch_en_first_b, fetch_en_first_a};
  assign ren2     = {fetch_en_second_b, fetch_en_second_a};
  assign oe_pin   = {out_drive_b, out_drive_a};
  assign din      = {data_in_b, data_in_a};

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer crossings
  logic [NUM_BUF-1:0][PW-1:0] wgray_s;
  logic [NUM_BUF-1:0][PW-1:0] rgray_s;

  for (genvar g = 0; g < NUM_BUF; g++) begin : g_sync
    // Write pointer towards the read side
    sfx_gray_sync #(.W(PW)) u_wsync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .clear    (clr[g]),
      .gray_in  (st_reg.fb[g].wgray),
      .gray_out (wgray_s[g])
    );
    // Read pointer towards the write side
    sfx_gray_sync #(.W(PW)) u_rsync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .clear    (clr[g]),
      .gray_in  (st_reg.fb[g].rgray),
      .gray_out (rgray_s[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [NUM_BUF-1:0]         w_rise;
  logic [NUM_BUF-1:0]         r_rise;
  logic [NUM_BUF-1:0]         store;
  logic [NUM_BUF-1:0]         fetch;
  logic [NUM_BUF-1:0][PW-1:0] wbin_n;
  logic [NUM_BUF-1:0][PW-1:0] rbin_n;
  logic [NUM_BUF-1:0][PW-1:0] wcnt;
  logic [NUM_BUF-1:0][PW-1:0] rcnt;
  logic [BUS_DW-1:0]          status;

  always_comb begin
    st_next = st_reg;
    status  = '0;
    w_rise  = '0;
    r_rise  = '0;
    store   = '0;
    fetch   = '0;
    wbin_n  = '0;
    rbin_n  = '0;
    wcnt    = '0;
    rcnt    = '0;

    for (int i = 0; i < NUM_BUF; i++) begin
      // Clock pins are synchronous to ref_clk, so a rise is one sample
      w_rise[i] = wclk_pin[i] & ~st_reg.fb[i].wclk_q;
      r_rise[i] = rclk_pin[i] & ~st_reg.fb[i].rclk_q;
      // In load mode the secondary pin no longer gates stores
      store[i]  = w_rise[i] & ~wen1[i] & (wen2[i] | ~st_reg.fb[i].dual)
                  & st_reg.fb[i].full_n;
      fetch[i]  = r_rise[i] & ~ren1[i] & ~ren2[i] & st_reg.fb[i].empty_n;
      wbin_n[i] = st_reg.fb[i].wbin + PW'(store[i]);
      rbin_n[i] = st_reg.fb[i].rbin + PW'(fetch[i]);
      wcnt[i]   = wbin_n[i] - PW'(sfx_gray2bin(CMP_W'(rgray_s[i])));
      rcnt[i]   = PW'(sfx_gray2bin(CMP_W'(wgray_s[i]))) - rbin_n[i];

      st_next.fb[i].wclk_q = wclk_pin[i];
      st_next.fb[i].rclk_q = rclk_pin[i];
      st_next.fb[i].oe     = oe_pin[i];

      if (clr[i]) begin
        // Back to empty; the strap is caught while clear is held
        st_next.fb[i].dual     = wen2[i];
        st_next.fb[i].wbin     = '0;
        st_next.fb[i].wgray    = '0;
        st_next.fb[i].rbin     = '0;
        st_next.fb[i].rgray    = '0;
        st_next.fb[i].empty_n  = 1'b0;
        st_next.fb[i].nempty_n = 1'b0;
        st_next.fb[i].full_n   = 1'b1;
        st_next.fb[i].nfull_n  = 1'b1;
        st_next.fb[i].rlevel   = '0;
      end else begin
        // Write side and its flags move only on a write-clock rise
        if (w_rise[i]) begin
          st_next.fb[i].wbin    = wbin_n[i];
          st_next.fb[i].wgray   = PW'(sfx_bin2gray(CMP_W'(wbin_n[i])));
          st_next.fb[i].full_n  = wcnt[i] != DEPTH_P;
          st_next.fb[i].nfull_n = CMP_W'(wcnt[i])
                                  < DEPTH_C - CMP_W'(st_reg.fb[i].af_off);
        end
        // Read side and its flags move only on a read-clock rise
        if (r_rise[i]) begin
          st_next.fb[i].rbin     = rbin_n[i];
          st_next.fb[i].rgray    = PW'(sfx_bin2gray(CMP_W'(rbin_n[i])));
          st_next.fb[i].empty_n  = rcnt[i] != '0;
          st_next.fb[i].nempty_n = CMP_W'(rcnt[i])
                                   > CMP_W'(st_reg.fb[i].ae_off);
          st_next.fb[i].rlevel   = CMP_W'(rcnt[i]);
        end
        if (fetch[i]) begin
          st_next.fb[i].dout = mem[i][st_reg.fb[i].rbin[AW-1:0]];
        end
      end

      status[i*ST_STRIDE+ST_EMPTY_N]  = st_reg.fb[i].empty_n;
      status[i*ST_STRIDE+ST_FULL_N]   = st_reg.fb[i].full_n;
      status[i*ST_STRIDE+ST_NEMPTY_N] = st_reg.fb[i].nempty_n;
      status[i*ST_STRIDE+ST_NFULL_N]  = st_reg.fb[i].nfull_n;
      status[i*ST_STRIDE+ST_DUAL]     = st_reg.fb[i].dual;
    end

    // Bus: one wait cycle, then the access completes at the low edge
    st_next.waitreq = 1'b1;
    if ((avs_read || avs_write) && st_reg.waitreq) begin
      st_next.waitreq = 1'b0;
      st_next.rdata   = '0;
      unique case (avs_address)
        ADDR_AE_OFF_A: st_next.rdata = BUS_DW'(st_reg.fb[0].ae_off);
        ADDR_AF_OFF_A: st_next.rdata = BUS_DW'(st_reg.fb[0].af_off);
        ADDR_AE_OFF_B: st_next.rdata = BUS_DW'(st_reg.fb[1].ae_off);
        ADDR_AF_OFF_B: st_next.rdata = BUS_DW'(st_reg.fb[1].af_off);
        ADDR_STATUS:   st_next.rdata = status;
        ADDR_LEVEL_A:  st_next.rdata = BUS_DW'(st_reg.fb[0].rlevel);
        ADDR_LEVEL_B:  st_next.rdata = BUS_DW'(st_reg.fb[1].rlevel);
        default:       st_next.rdata = '0;
      endcase
    end
    // Threshold writes, resolution of one word
    if (avs_write && !st_reg.waitreq) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        if (avs_address == (i == 0 ? ADDR_AE_OFF_A : ADDR_AE_OFF_B)) begin
          if (avs_byteenable[0]) st_next.fb[i].ae_off[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) st_next.fb[i].ae_off[12:8] = avs_writedata[12:8];
        end
        if (avs_address == (i == 0 ? ADDR_AF_OFF_A : ADDR_AF_OFF_B)) begin
          if (avs_byteenable[0]) st_next.fb[i].af_off[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) st_next.fb[i].af_off[12:8] = avs_writedata[12:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.waitreq <= 1'b1;
      for (int i = 0; i < NUM_BUF; i++) begin
        st_reg.fb[i].dual    <= 1'b1;
        st_reg.fb[i].full_n  <= 1'b1;
        st_reg.fb[i].nfull_n <= 1'b1;
        st_reg.fb[i].ae_off  <= OFF_RST;
        st_reg.fb[i].af_off  <= OFF_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // Memory has no reset; content before the first store is never fetched
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NUM_BUF; i++) begin
      if (store[i] && !clr[i]) begin
        mem[i][st_reg.fb[i].wbin[AW-1:0]] <= din[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign data_out_a      = st_reg.fb[0].dout;
  assign data_drive_a    = st_reg.fb[0].oe;
  assign buf_empty_n_a   = st_reg.fb[0].empty_n;
  assign buf_full_n_a    = st_reg.fb[0].full_n;
  assign near_empty_n_a  = st_reg.fb[0].nempty_n;
  assign near_full_n_a   = st_reg.fb[0].nfull_n;
  assign data_out_b      = st_reg.fb[1].dout;
  assign data_drive_b    = st_reg.fb[1].oe;
  assign buf_empty_n_b   = st_reg.fb[1].empty_n;
  assign buf_full_n_b    = st_reg.fb[1].full_n;
  assign near_empty_n_b  = st_reg.fb[1].nempty_n;
  assign near_full_n_b   = st_reg.fb[1].nfull_n;

endmodule // sfx_dual_fifo

// >>> hdl/sfx_gray_sync.sv
`timescale 1ns/10ps
module sfx_gray_sync #(
  parameter int W = 9
) (
  // Clock and resets
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  // Pointer in and synchronised copy out
  input  wire logic [W-1:0] gray_in,
  output logic      [W-1:0] gray_out
);
  import sfx_pkg::*;

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sfx_sync_type;

  sfx_sync_type st_reg;
  sfx_sync_type st_next;

  // Stage one feeds stage two only; gray code limits a skew to one bit
  always_comb begin
    st_next        = st_reg;
    st_next.stage1 = clear ? '0 : gray_in;
    st_next.stage2 = clear ? '0 : st_reg.stage1;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gray_out = st_reg.stage2;

endmodule // sfx_gray_sync
